/* File: inc/lirc_defs.svh */
`ifndef LIRC_DEFS_SVH
`define LIRC_DEFS_SVH

// Clock and pixel reset timing
`define LIRC_CLK_NS 20
`define LIRC_T_RST_NS 200
`define LIRC_RST_CYC ((`LIRC_T_RST_NS + `LIRC_CLK_NS - 1) / `LIRC_CLK_NS)

// Controller register offsets
`define LIRC_OFF_CTRL 12'h000
`define LIRC_OFF_INTEG 12'h004
`define LIRC_OFF_REPEAT 12'h008
`define LIRC_OFF_STATUS 12'h00c

// Control register fields
`define LIRC_CTRL_GO 0
`define LIRC_CTRL_MODE 1
`define LIRC_CTRL_BIN_LO 2
`define LIRC_CTRL_BIN_HI 3
`define LIRC_CTRL_STBY 4

// Status register fields
`define LIRC_ST_BUSY 0
`define LIRC_ST_STBY 1
`define LIRC_ST_FIRST 2
`define LIRC_ST_FCNT_LO 8

// Reset values
`define LIRC_INTEG_RST 16'h0064
`define LIRC_REPEAT_RST 8'h00

// Sensor geometry
`define LIRC_NPIX 1024
`define LIRC_NAMP 8

`endif

/* File: inc/lirc_pkg.sv */
package lirc_pkg;

  typedef enum logic [2:0] {
    LIRC_IDLE = 3'b000,
    LIRC_PRST = 3'b001,
    LIRC_INTG = 3'b010,
    LIRC_READ = 3'b011,
    LIRC_WAIT = 3'b100,
    LIRC_GAP = 3'b101
  } lirc_state_t;

  typedef logic [1:0] lirc_bin_t;

  // Pixels per frame for a bin selection
  function automatic logic [10:0] lirc_frame_len(input lirc_bin_t b);
    lirc_frame_len = 11'h400 >> b;
  endfunction

endpackage

/* File: inc/lirc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lirc_if;
  logic rst_in;
  logic shutter_in;
  logic start_readout;
  logic reset_mode_sel;
  logic bin_select_lo;
  logic bin_select_hi;
  logic video_valid;
  logic [9:0] video_pixel;
  logic video_combined;

  modport sensor (
    input rst_in, shutter_in, start_readout, reset_mode_sel,
    input bin_select_lo, bin_select_hi,
    output video_valid, video_pixel, video_combined
  );
  modport ctrl (
    output rst_in, shutter_in, start_readout, reset_mode_sel,
    output bin_select_lo, bin_select_hi,
    input video_valid, video_pixel, video_combined
  );
endinterface
`default_nettype wire

/* File: verilog/lirc_sensor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lirc_defs.svh"

// Functional notes
// R1 - Reset and start high together: standby
// R2 - Pixel clock activity ignored during standby
// R3 - Unused amplifiers off at reduced resolution
// R4 - Frame mode driven by reset, shutter, start
// R5 - Reset and shutter act asynchronously
// R6 - Reset with shutter high resets all pixels
// R7 - Reset high clears and stops shift register
// R8 - Integrate from reset fall to shutter fall
// R9 - Readout starts edge after start sampled
// R10 - Long start pulse repeats pixel 1 combined
// R11 - Every reset restarts readout at pixel 1
// R12 - Repeated readouts leave pixels unreset
// R13 - Mode 1 resets pixels internally
// R14 - Mode 1: reset input only resets logic
// R15 - Mode 1: shutter kept high by controller
// R16 - Mode 1: first frame discarded by controller
// R17 - Mode 1: pixel reset cycle after readout
// R18 - Mode 1: integration is period minus one
// R19 - Any gap between frames allowed
// R20 - Bin select picks 1024/512/256/128 resolution
// R21 - Frame length equals selected pixel count
// R22 - Readout stops after last pixel
module lirc_sensor
  import lirc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  lirc_if.sensor link,
  output logic standby,
  output logic [`LIRC_NAMP-1:0] amp_en,
  output logic out_amp_en,
  output logic array_reset,
  output logic integrating,
  output logic dpr_reset_valid,
  output logic [9:0] dpr_reset_pixel
);

  lirc_bin_t bin;
  logic [10:0] frame_len;
  logic [9:0] pos_reg;
  logic active_reg;
  logic first_reg;
  logic valid_reg;
  logic [9:0] pix_reg;
  logic comb_reg;
  logic integ_reg;
  logic rst_d_reg;
  logic dpr_valid_reg;
  logic [9:0] dpr_pix_reg;
  logic last;
  logic [9:0] pix_next;

  assign bin = {link.bin_select_hi, link.bin_select_lo}; // [R20]
  assign frame_len = lirc_frame_len(bin); // [R21]

  // Standby is a level decode of the two pins
  assign standby = link.rst_in & link.start_readout; // [R1]

  // Amplifier groups used by the current binning
  genvar g;
  generate
    for (g = 0; g < `LIRC_NAMP; g = g + 1) begin : g_amp
      assign amp_en[g] = !standby &&
        (11'(g) < (11'(`LIRC_NAMP) >> bin)); // [R3] [R1]
    end
  endgenerate

  assign out_amp_en = !standby; // [R1]

  // Global pixel reset follows the pins without sampling
  assign array_reset = link.rst_in & link.shutter_in &
                       !link.reset_mode_sel; // [R5] [R6] [R13] [R14]

  assign last = ({1'b0, pos_reg} == frame_len - 11'h001);
  assign pix_next = 10'(pos_reg << bin);

  // Readout position in the shift register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 10'h000;
      active_reg <= 1'b0;
      first_reg <= 1'b0;
    end else if (link.rst_in) begin
      pos_reg <= 10'h000; // [R7] [R11] [R14]
      active_reg <= 1'b0;
      first_reg <= 1'b0;
    end else if (link.start_readout) begin
      // Pixel 0 goes out now, so hold the next position
      pos_reg <= 10'h001; // [R9] [R12] [R19]
      active_reg <= 1'b1;
      first_reg <= 1'b1;
    end else if (active_reg) begin
      first_reg <= 1'b0;
      if (last) begin
        active_reg <= 1'b0; // [R22]
        pos_reg <= 10'h000;
      end else begin
        pos_reg <= pos_reg + 10'h001; // [R21]
      end
    end
  end

  // Video output, one pixel group per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_reg <= 1'b0;
      pix_reg <= 10'h000;
      comb_reg <= 1'b0;
    end else if (link.rst_in) begin
      valid_reg <= 1'b0; // [R2] [R7]
      pix_reg <= 10'h000;
      comb_reg <= 1'b0;
    end else if (link.start_readout) begin
      valid_reg <= 1'b1; // [R9]
      pix_reg <= 10'h000;
      comb_reg <= first_reg; // [R10]
    end else if (active_reg) begin
      valid_reg <= 1'b1;
      pix_reg <= pix_next;
      comb_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      comb_reg <= 1'b0;
    end
  end

  assign link.video_valid = valid_reg;
  assign link.video_pixel = pix_reg;
  assign link.video_combined = comb_reg;

  // Internal per-pixel reset, one cycle behind readout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpr_valid_reg <= 1'b0;
      dpr_pix_reg <= 10'h000;
    end else if (link.rst_in || !link.reset_mode_sel) begin
      dpr_valid_reg <= 1'b0; // [R13] [R14]
    end else begin
      dpr_valid_reg <= valid_reg; // [R17] [R18]
      dpr_pix_reg <= pix_reg;
    end
  end

  assign dpr_reset_valid = dpr_valid_reg;
  assign dpr_reset_pixel = dpr_pix_reg;

  // Frame mode integration window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_d_reg <= 1'b0;
      integ_reg <= 1'b0;
    end else begin
      rst_d_reg <= link.rst_in;
      if (link.reset_mode_sel) begin
        integ_reg <= link.shutter_in; // [R15]
      end else if (!link.shutter_in || link.rst_in) begin
        integ_reg <= 1'b0; // [R8]
      end else if (rst_d_reg) begin
        integ_reg <= 1'b1; // [R8] [R12]
      end
    end
  end

  assign integrating = integ_reg;

endmodule
`default_nettype wire

/* File: verilog/lirc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lirc_defs.svh"

module lirc_ctrl
  import lirc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lirc_if.ctrl link,
  output logic pix_valid,
  output logic [9:0] pix_data
);

  lirc_state_t state_reg;
  logic mode_reg;
  lirc_bin_t bin_reg;
  logic stby_reg;
  logic [15:0] integ_reg;
  logic [7:0] repeat_reg;
  logic [15:0] cnt_reg;
  logic [7:0] left_reg;
  logic [7:0] fcnt_reg;
  logic first_reg;
  logic pv_reg;
  logic [9:0] pd_reg;
  logic wr;
  logic go;
  logic busy;
  logic [15:0] flen;

  assign wr = psel & penable & pwrite;
  assign go = wr && paddr == `LIRC_OFF_CTRL && pwdata[`LIRC_CTRL_GO];
  assign busy = (state_reg != LIRC_IDLE);
  assign flen = {5'h00, lirc_frame_len(bin_reg)};
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    if (paddr == `LIRC_OFF_CTRL) begin
      prdata[`LIRC_CTRL_MODE] = mode_reg;
      prdata[`LIRC_CTRL_BIN_HI:`LIRC_CTRL_BIN_LO] = bin_reg;
      prdata[`LIRC_CTRL_STBY] = stby_reg;
    end else if (paddr == `LIRC_OFF_INTEG) begin
      prdata[15:0] = integ_reg;
    end else if (paddr == `LIRC_OFF_REPEAT) begin
      prdata[7:0] = repeat_reg;
    end else if (paddr == `LIRC_OFF_STATUS) begin
      prdata[`LIRC_ST_BUSY] = busy;
      prdata[`LIRC_ST_STBY] = stby_reg & !busy;
      prdata[`LIRC_ST_FIRST] = first_reg;
      prdata[`LIRC_ST_FCNT_LO+7:`LIRC_ST_FCNT_LO] = fcnt_reg;
    end else begin
      pslverr = psel & penable;
    end
  end

  // Configuration registers, frozen while a sequence runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 1'b0;
      bin_reg <= 2'h0;
      stby_reg <= 1'b0;
      integ_reg <= `LIRC_INTEG_RST;
      repeat_reg <= `LIRC_REPEAT_RST;
    end else if (wr && !busy) begin
      if (paddr == `LIRC_OFF_CTRL) begin
        mode_reg <= pwdata[`LIRC_CTRL_MODE];
        bin_reg <= pwdata[`LIRC_CTRL_BIN_HI:`LIRC_CTRL_BIN_LO];
        stby_reg <= pwdata[`LIRC_CTRL_STBY];
      end else if (paddr == `LIRC_OFF_INTEG) begin
        integ_reg <= pwdata[15:0];
      end else if (paddr == `LIRC_OFF_REPEAT) begin
        repeat_reg <= pwdata[7:0];
      end
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= LIRC_IDLE;
      cnt_reg <= 16'h0000;
      left_reg <= 8'h00;
      fcnt_reg <= 8'h00;
      first_reg <= 1'b0;
    end else begin
      case (state_reg)
        LIRC_IDLE: begin
          if (go && !busy) begin
            left_reg <= repeat_reg;
            fcnt_reg <= 8'h00;
            // Mode arrives with go, so take it from the write
            first_reg <= pwdata[`LIRC_CTRL_MODE]; // [R16]
            cnt_reg <= 16'h0000;
            state_reg <= pwdata[`LIRC_CTRL_MODE] ?
                         LIRC_READ : LIRC_PRST; // [R4] [R13]
          end
        end
        LIRC_PRST: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(`LIRC_RST_CYC - 1)) begin // [R6]
            cnt_reg <= 16'h0000;
            state_reg <= LIRC_INTG;
          end
        end
        LIRC_INTG: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= integ_reg) begin // [R8]
            state_reg <= LIRC_READ;
          end
        end
        LIRC_READ: begin
          cnt_reg <= 16'h0001;
          state_reg <= LIRC_WAIT; // [R10]
        end
        LIRC_WAIT: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == flen) begin // [R21]
            cnt_reg <= 16'h0000;
            fcnt_reg <= fcnt_reg + 8'h01;
            if (fcnt_reg != 8'h00) begin
              first_reg <= 1'b0;
            end
            if (left_reg == 8'h00) begin
              state_reg <= LIRC_IDLE;
            end else begin
              left_reg <= left_reg - 8'h01;
              state_reg <= mode_reg ? LIRC_GAP : LIRC_READ; // [R12]
            end
          end
        end
        LIRC_GAP: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= integ_reg) begin // [R18] [R19]
            state_reg <= LIRC_READ;
          end
        end
        default: begin
          state_reg <= LIRC_IDLE;
        end
      endcase
    end
  end

  // Pin drive; in mode 1 reset stays low outside standby and shutter high
  always_comb begin
    link.rst_in = (state_reg == LIRC_PRST) ||
                  (stby_reg && !busy); // [R1] [R6] [R14]
    link.shutter_in = mode_reg || state_reg == LIRC_PRST ||
                      state_reg == LIRC_INTG; // [R6] [R8] [R15]
    link.start_readout = (state_reg == LIRC_READ) ||
                         (stby_reg && !busy); // [R1] [R9] [R10]
  end
  assign link.reset_mode_sel = mode_reg;
  assign link.bin_select_lo = bin_reg[0];
  assign link.bin_select_hi = bin_reg[1];

  // Captured video; first mode-1 frame is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_reg <= 1'b0;
      pd_reg <= 10'h000;
    end else begin
      pv_reg <= link.video_valid && !(mode_reg && first_reg &&
                fcnt_reg == 8'h00); // [R16]
      pd_reg <= link.video_pixel;
    end
  end

  assign pix_valid = pv_reg;
  assign pix_data = pd_reg;

endmodule
`default_nettype wire

/* File: sim/lirc_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lirc_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rst_in,
  input wire logic shutter_in,
  input wire logic start_readout,
  input wire logic reset_mode_sel,
  input wire logic bin_select_lo,
  input wire logic bin_select_hi,
  input wire logic video_valid,
  input wire logic [9:0] video_pixel,
  input wire logic video_combined
);
  logic [10:0] step;
  logic [10:0] nxt;
  assign step = 11'h001 << {bin_select_hi, bin_select_lo};
  assign nxt = {1'b0, video_pixel} + step;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go;
    start_readout && !rst_in;
  endsequence
  sequence s_adv;
    video_valid && !start_readout && !rst_in;
  endsequence
  sequence s_hold;
    (rst_in && shutter_in)[*5] ##1 (rst_in && shutter_in)[*5];
  endsequence
  AST_FIRST: assert property (
    s_go |=> video_valid && video_pixel == 10'h000 && !video_combined)
    else $error("frame did not open at pixel 0");
  AST_RSTCLR: assert property (rst_in |=> !video_valid)
    else $error("video while reset high");
  AST_STEP: assert property (
    s_adv ##0 nxt < 11'h400 |=> video_valid &&
    {1'b0, video_pixel} == $past(nxt))
    else $error("pixel did not advance by the bin step");
  AST_LAST: assert property (s_adv ##0 nxt == 11'h400 |=> !video_valid)
    else $error("readout ran past the last pixel");
  AST_PULSE: assert property (s_go |=> !start_readout)
    else $error("start held over a second edge");
  AST_HOLD: assert property (
    $rose(rst_in && shutter_in) && !reset_mode_sel && !start_readout
    |-> s_hold)
    else $error("pixel reset shorter than 10 cycles");
  AST_DPRRST: assert property (
    reset_mode_sel && !start_readout |-> !rst_in)
    else $error("reset input high in dynamic mode");
  AST_DPRSHUT: assert property (
    reset_mode_sel && start_readout |-> shutter_in)
    else $error("shutter low in dynamic mode");
endmodule
`default_nettype wire

/* File: sim/linear_imager_readout_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lirc_defs.svh"
module linear_imager_readout_control_tb
  import lirc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, pix_valid, standby, out_amp_en, perr;
  logic [9:0] pix_data, dpr_pix;
  logic array_reset, integrating, dpr_valid;
  logic [7:0] amp_en;
  logic [15:0] integ;
  logic [9:0] exp_q[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  lirc_if link_if();
  lirc_sensor lirc_sensor_i (.pclk(pclk), .presetn(presetn),
    .link(link_if), .standby(standby), .amp_en(amp_en),
    .out_amp_en(out_amp_en), .array_reset(array_reset),
    .integrating(integrating), .dpr_reset_valid(dpr_valid),
    .dpr_reset_pixel(dpr_pix));
  lirc_ctrl lirc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if),
    .pix_valid(pix_valid), .pix_data(pix_data));
  lirc_link_sva lirc_link_sva_i (.pclk(pclk), .presetn(presetn),
    .rst_in(link_if.rst_in), .shutter_in(link_if.shutter_in),
    .start_readout(link_if.start_readout),
    .reset_mode_sel(link_if.reset_mode_sel),
    .bin_select_lo(link_if.bin_select_lo),
    .bin_select_hi(link_if.bin_select_hi),
    .video_valid(link_if.video_valid), .video_pixel(link_if.video_pixel),
    .video_combined(link_if.video_combined));

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pix(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: pixel %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp_word(rdat, exp);
  endtask

  // Busy stays up until the last frame is out
  task automatic wait_idle();
    do apb(1'b0, `LIRC_OFF_STATUS, 32'h0); while (rdat[0] === 1'b1);
  endtask

  task automatic run(input logic m, input lirc_bin_t b, input logic [7:0] r);
    integ = 16'($urandom_range(12, 0));
    apb(1'b1, `LIRC_OFF_INTEG, {16'h0, integ});
    apb(1'b1, `LIRC_OFF_REPEAT, {24'h0, r});
    for (int f = 0; f <= r; f++) begin
      if (!(m && f == 0)) begin
        for (int k = 0; k < (1024 >> b); k++) exp_q.push_back(10'(k << b));
      end
    end
    apb(1'b1, `LIRC_OFF_CTRL, {27'h0, 1'b0, b, m, 1'b1});
    @(negedge pclk);
    cmp_word({24'h0, amp_en}, {24'h0, 8'hff >> (8 - (8 >> b))});
    cmp_word({31'h0, array_reset}, {31'h0, !m});
    // Written while busy, so it must be dropped
    apb(1'b1, `LIRC_OFF_INTEG, 32'h0000_0033);
    wait_idle();
    cmp_word({31'h0, integrating}, {31'h0, m});
    rd(`LIRC_OFF_INTEG, {16'h0, integ});
    cmp_word(32'(exp_q.size()), 32'h0);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pix_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("Error %0t: unexpected pixel", $time);
      end else cmp_pix(pix_data, exp_q.pop_front());
    end
    if (dpr_valid === 1'b1) cmp_pix(dpr_pix, pix_data);
    if (cyc > 30000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(94));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`LIRC_OFF_CTRL, 32'h0);
    rd(`LIRC_OFF_INTEG, {16'h0, `LIRC_INTEG_RST});
    rd(`LIRC_OFF_REPEAT, 32'h0);
    rd(`LIRC_OFF_STATUS, 32'h0);
    rd(12'h010, 32'h0);
    cmp_word({31'h0, perr}, 32'h1);
    apb(1'b1, `LIRC_OFF_CTRL, 32'h10);
    repeat (5) @(negedge pclk);
    cmp_word({29'h0, standby, out_amp_en, |amp_en}, 32'h4);
    rd(`LIRC_OFF_STATUS, 32'h2);
    apb(1'b1, `LIRC_OFF_CTRL, 32'h0);
    for (int b = 0; b < 4; b++) run(1'b0, 2'(b), 8'(b == 3));
    run(1'b1, 2'h3, 8'h2);
    run(1'b1, 2'h1, 8'h1);
    stop_test();
  end
endmodule
`default_nettype wire
